// [hw/sdam_mapper.sv]
`timescale 1ns/1ps
module sdam_mapper
   import sdam_pkg::*;
(
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rstn_i,
   // Geometry configuration
   input  wire sdam_pkg::sdam_bus_e          cfg_bus_i,
   input  wire sdam_pkg::sdam_rows_e         cfg_rows_i,
   input  wire sdam_pkg::sdam_cols_e         cfg_cols_i,
   // Request from system bus master
   input  wire logic                         req_valid_i,
   input  wire logic [sdam_pkg::ADDR_W-1:0]  req_addr_i,
   input  wire sdam_pkg::sdam_size_e         req_size_i,
   // Decomposed address toward the command sequencer
   output logic                              map_valid_o,
   output logic [sdam_pkg::ROW_W_MAX-1:0]    map_row_o,
   output logic [sdam_pkg::COL_W_MAX-1:0]    map_col_o,
   output logic [1:0]                        map_byte_offset_o,
   output logic                              halfword_byte_offset_o,
   output logic [sdam_pkg::BANK_W-1:0]       memory_group_field_o,
   output logic                              memory_group_select_high_o,
   output logic                              memory_group_select_low_o,
   output logic [sdam_pkg::LANE_W-1:0]       map_lanes_o
);
   import sdam_pkg::*;

   // ==========================================================================
   // Reset release
   logic [1:0] rst_sync_q;
   logic       rst_n;

   // Async assert, two-flop release
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // ==========================================================================
   // Geometry helpers
   function automatic logic [4:0] row_width(input sdam_rows_e r);
      row_width = ROW_W_2K + 5'(r);
   endfunction

   function automatic logic [4:0] col_width(input sdam_cols_e c);
      col_width = COL_W_256 + 5'(c);
   endfunction

   // Mask of the low n bits
   function automatic logic [ADDR_W-1:0] low_mask(input logic [4:0] n);
      low_mask = ~({ADDR_W{1'b1}} << n);
   endfunction

   // ==========================================================================
   // State
   typedef struct packed {
      logic                    valid;
      logic [ROW_W_MAX-1:0]    row;
      logic [COL_W_MAX-1:0]    col;
      logic [1:0]              offs;
      logic                    hoffs;
      logic [BANK_W-1:0]       bank;
      logic [LANE_W-1:0]       lanes;
   } sdam_state_s;

   sdam_state_s st_q;
   sdam_state_s st_d;

   logic [LANE_W-1:0] lanes;
   logic [4:0]        col_base;
   logic [4:0]        col_w;
   logic [4:0]        row_w;
   logic [4:0]        row_base;
   logic [4:0]        bank_base;

   // Lane selection is shared with other paths, kept in its own leaf
   sdam_lane_dec u_lane_dec
   (
      .bus_i   (cfg_bus_i),
      .size_i  (req_size_i),
      .offs_i  (req_addr_i[1:0]),
      .lanes_o (lanes)
   );

   // Field positions from geometry
   assign col_base  = (cfg_bus_i == SDAM_BUS_32) ? COL_BASE_32 : COL_BASE_16;
   assign col_w     = col_width(cfg_cols_i);
   assign row_w     = row_width(cfg_rows_i);
   assign row_base  = col_base + col_w;
   assign bank_base = row_base + row_w;

   // ==========================================================================
   // Next state: split the address when a request arrives, else hold fields
   // Fields are held so the sequencer sees stable lines between requests
   always_comb
   begin
      logic [ADDR_W-1:0] a;
      a    = req_addr_i;
      st_d = st_q;
      st_d.valid = req_valid_i;
      if (req_valid_i)
      begin
         st_d.col  = COL_W_MAX'((a >> col_base) & low_mask(col_w));
         st_d.row  = ROW_W_MAX'((a >> row_base) & low_mask(row_w));
         st_d.bank = BANK_W'(a >> bank_base);
         st_d.offs = (cfg_bus_i == SDAM_BUS_32) ? a[1:0] : {1'b0, a[0]};
         st_d.hoffs = a[0];
         st_d.lanes = lanes;
      end
   end

   // Register the state
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   // ==========================================================================
   // Outputs straight from flops
   assign map_valid_o                = st_q.valid;
   assign map_row_o                  = st_q.row;
   assign map_col_o                  = st_q.col;
   assign map_byte_offset_o          = st_q.offs;
   assign halfword_byte_offset_o     = st_q.hoffs;
   assign memory_group_field_o       = st_q.bank;
   assign memory_group_select_high_o = st_q.bank[1];
   assign memory_group_select_low_o  = st_q.bank[0];

   assign map_lanes_o                = st_q.lanes;

   // ==========================================================================
   // Checks
   AST_COL32: assert property (@(posedge clk_i) disable iff (!rst_n)
      req_valid_i && cfg_bus_i == SDAM_BUS_32 && cfg_cols_i == SDAM_COLS_256
      |=> map_col_o == COL_W_MAX'($past(req_addr_i[9:2])))
      else $error("column not at bit 2 on 32-bit bus");

   AST_COL16: assert property (@(posedge clk_i) disable iff (!rst_n)
      req_valid_i && cfg_bus_i == SDAM_BUS_16 && cfg_cols_i == SDAM_COLS_2048
      |=> map_col_o == $past(req_addr_i[11:1]) && halfword_byte_offset_o == $past(req_addr_i[0]))
      else $error("column not at bit 1 on 16-bit bus");

   AST_ROW8K: assert property (@(posedge clk_i) disable iff (!rst_n)
      req_valid_i && cfg_bus_i == SDAM_BUS_32 && cfg_rows_i == SDAM_ROWS_8K
      && cfg_cols_i == SDAM_COLS_256
      |=> map_row_o == $past(req_addr_i[22:10]))
      else $error("8K row field misplaced");

   AST_ROW2K: assert property (@(posedge clk_i) disable iff (!rst_n)
      req_valid_i && cfg_rows_i == SDAM_ROWS_2K |=> map_row_o[12:11] == 2'h0)
      else $error("2K row field too wide");

   AST_BANK: assert property (@(posedge clk_i) disable iff (!rst_n)
      req_valid_i && cfg_bus_i == SDAM_BUS_16 && cfg_rows_i == SDAM_ROWS_4K
      && cfg_cols_i == SDAM_COLS_512
      |=> memory_group_field_o == $past(req_addr_i[23:22]))
      else $error("bank field misplaced");

   AST_PINS: assert property (@(posedge clk_i) disable iff (!rst_n)
      {memory_group_select_high_o, memory_group_select_low_o} == memory_group_field_o)
      else $error("bank select pins swapped");

   AST_ALIAS: assert property (@(posedge clk_i) disable iff (!rst_n)
      req_valid_i && cfg_bus_i == SDAM_BUS_32 && cfg_rows_i == SDAM_ROWS_2K
      && cfg_cols_i == SDAM_COLS_256 ##1 req_valid_i && $stable(cfg_bus_i)
      && $stable(cfg_rows_i) && $stable(cfg_cols_i)
      && req_addr_i[22:0] == $past(req_addr_i[22:0])
      |=> $stable(memory_group_field_o) && $stable(map_row_o))
      else $error("upper address bits do not alias");

   AST_LANES: assert property (@(posedge clk_i) disable iff (!rst_n)
      req_valid_i && cfg_bus_i == SDAM_BUS_32 && req_size_i == SDAM_SIZE_BYTE
      |=> map_lanes_o == (LANE_BYTE << $past(req_addr_i[1:0])))
      else $error("byte lane wrong");

   AST_OFFS: assert property (@(posedge clk_i) disable iff (!rst_n)
      req_valid_i && cfg_bus_i == SDAM_BUS_32 |=> map_byte_offset_o == $past(req_addr_i[1:0]))
      else $error("word byte offset wrong");

   AST_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
      !req_valid_i |=> !map_valid_o && $stable(map_row_o) && $stable(map_col_o))
      else $error("fields changed without request");

   // The sequencer may sample bank, offset and lanes late, so they must hold too
   AST_HOLDB: assert property (@(posedge clk_i) disable iff (!rst_n)
      !req_valid_i |=> $stable(memory_group_field_o) && $stable(map_byte_offset_o)
      && $stable(map_lanes_o))
      else $error("bank, offset or lanes changed without request");

   AST_LANES16: assert property (@(posedge clk_i) disable iff (!rst_n)
      req_valid_i && cfg_bus_i == SDAM_BUS_16 && req_size_i == SDAM_SIZE_BYTE
      |=> map_lanes_o == (LANE_BYTE << $past(req_addr_i[0])))
      else $error("byte lane wrong on 16-bit bus");

   // Unused column lines must stay low or the device sees a wrong column
   AST_COLHI: assert property (@(posedge clk_i) disable iff (!rst_n)
      req_valid_i && cfg_cols_i == SDAM_COLS_256 |=> map_col_o[10:8] == 3'h0)
      else $error("256-column field too wide");

   COV_32: cover property (@(posedge clk_i) disable iff (!rst_n)
      req_valid_i && cfg_bus_i == SDAM_BUS_32 && cfg_rows_i == SDAM_ROWS_8K);
   COV_16: cover property (@(posedge clk_i) disable iff (!rst_n)
      req_valid_i && cfg_bus_i == SDAM_BUS_16 && cfg_cols_i == SDAM_COLS_2048);
   COV_B2B: cover property (@(posedge clk_i) disable iff (!rst_n)
      req_valid_i ##1 req_valid_i);
   COV_ALIAS: cover property (@(posedge clk_i) disable iff (!rst_n)
      req_valid_i && req_addr_i[22:0] == 23'h0 ##1 req_valid_i && req_addr_i[27:23] != 5'h0);

endmodule

// [pkg/sdam_pkg.sv]
package sdam_pkg;

   // ==========================================================================
   // Address and field widths
   localparam int unsigned ADDR_W     = 28;
   localparam int unsigned ROW_W_MAX  = 13;
   localparam int unsigned COL_W_MAX  = 11;
   localparam int unsigned BANK_W     = 2;
   localparam int unsigned LANE_W     = 4;

   // ==========================================================================
   // Geometry encodings
   typedef enum logic [0:0] {
      SDAM_BUS_16 = 1'h0,
      SDAM_BUS_32 = 1'h1
   } sdam_bus_e;

   typedef enum logic [1:0] {
      SDAM_ROWS_2K = 2'h0,
      SDAM_ROWS_4K = 2'h1,
      SDAM_ROWS_8K = 2'h2
   } sdam_rows_e;

   typedef enum logic [1:0] {
      SDAM_COLS_256  = 2'h0,
      SDAM_COLS_512  = 2'h1,
      SDAM_COLS_1024 = 2'h2,
      SDAM_COLS_2048 = 2'h3
   } sdam_cols_e;

   // Access sizes
   typedef enum logic [1:0] {
      SDAM_SIZE_BYTE = 2'h0,
      SDAM_SIZE_HALF = 2'h1,
      SDAM_SIZE_WORD = 2'h2
   } sdam_size_e;

   // ==========================================================================
   // Field bases and widths
   localparam logic [4:0] COL_BASE_32 = 5'h02;
   localparam logic [4:0] COL_BASE_16 = 5'h01;
   localparam logic [4:0] ROW_W_2K    = 5'h0B;
   localparam logic [4:0] COL_W_256   = 5'h08;
   localparam logic [LANE_W-1:0] LANES_NONE = 4'h0;
   localparam logic [LANE_W-1:0] LANE_BYTE  = 4'h1;
   localparam logic [LANE_W-1:0] LANE_HALF  = 4'h3;
   localparam logic [LANE_W-1:0] LANE_WORD  = 4'hF;

endpackage

// [hw/sdam_lane_dec.sv]
`timescale 1ns/1ps
module sdam_lane_dec
   import sdam_pkg::*;
(
   // Access description
   input  wire sdam_bus_e           bus_i,
   input  wire sdam_size_e          size_i,
   input  wire logic [1:0]          offs_i,
   // Active byte lanes, high = lane used
   output logic [sdam_pkg::LANE_W-1:0] lanes_o
);

   // ==========================================================================
   // Lane decode
   // Half-word offsets ignore bit 0; misaligned halves are forced aligned
   always_comb
   begin
      logic [LANE_W-1:0] base;
      base = LANES_NONE;
      unique case (size_i)
         SDAM_SIZE_BYTE: base = LANE_BYTE << offs_i;
         SDAM_SIZE_HALF: base = LANE_HALF << {offs_i[1], 1'b0};
         SDAM_SIZE_WORD: base = LANE_WORD;
         default:        base = LANES_NONE;
      endcase
      // A 16-bit bus only has two lanes; bit 1 of the offset is not a lane
      if (bus_i == SDAM_BUS_16)
      begin
         unique case (size_i)
            SDAM_SIZE_BYTE: base = LANE_BYTE << offs_i[0];
            SDAM_SIZE_HALF: base = LANE_HALF;
            SDAM_SIZE_WORD: base = LANE_HALF;
            default:        base = LANES_NONE;
         endcase
      end
      lanes_o = base;
   end

endmodule

// [dv/sdam_sdram_model.sv]
`timescale 1ns/1ps
module sdam_sdram_model
   import sdam_pkg::*;
(
   // Clock
   input  wire logic                             clk_i,
   // Mapped request seen at the memory pins
   input  wire logic                             valid_i,
   input  wire logic                             group_high_i,
   input  wire logic                             group_low_i,
   input  wire logic [sdam_pkg::ROW_W_MAX-1:0]   row_i,
   input  wire logic [sdam_pkg::COL_W_MAX-1:0]   col_i,
   // Last location opened: bank, row, column
   output logic      [25:0]                      loc_o
);
   // ==========================================================================
   // Location latch
   // Idle cycles leave the last location alone, as an open row would stay open
   always_ff @(posedge clk_i)
   begin
      if (valid_i)
      begin
         loc_o <= {group_high_i, group_low_i, row_i, col_i};
      end
   end
endmodule

// [dv/sdram_address_mapper_tb.sv]
`timescale 1ns/1ps
module sdram_address_mapper_tb;
   import sdam_pkg::*;
   // ==========================================================================
   // Stimulus and observation
   logic clk_i, rstn_i, req_valid_i, map_valid_o, hb_o, gh_o, gl_o;
   sdam_bus_e  cfg_bus_i;
   sdam_rows_e cfg_rows_i;
   sdam_cols_e cfg_cols_i;
   sdam_size_e req_size_i;
   logic [27:0] req_addr_i;
   logic [12:0] row_o;
   logic [10:0] col_o;
   logic [1:0]  offs_o, grp_o;
   logic [3:0]  lanes_o;
   logic [25:0] loc, lag;
   logic [32:0] ex;
   logic        ev;
   bit          ok1, ok2;
   int          fails, check_count, cycles, gb, gr, gc;

   sdam_mapper dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .cfg_bus_i(cfg_bus_i),
      .cfg_rows_i(cfg_rows_i), .cfg_cols_i(cfg_cols_i), .req_valid_i(req_valid_i),
      .req_addr_i(req_addr_i), .req_size_i(req_size_i), .map_valid_o(map_valid_o),
      .map_row_o(row_o), .map_col_o(col_o), .map_byte_offset_o(offs_o),
      .halfword_byte_offset_o(hb_o), .memory_group_field_o(grp_o),
      .memory_group_select_high_o(gh_o), .memory_group_select_low_o(gl_o),
      .map_lanes_o(lanes_o));

   sdam_sdram_model model_u (.clk_i(clk_i), .valid_i(map_valid_o), .group_high_i(gh_o),
      .group_low_i(gl_o), .row_i(row_o), .col_i(col_o), .loc_o(loc));

   // Clock generation
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // ==========================================================================
   // Expected split: bank, row, column, offset, half-word bit, lanes
   function automatic logic [32:0] exp_map(int b, int r, int c, int s, logic [27:0] a);
      int cb, cw, rw;
      logic [3:0] ln;
      cb = b ? 2 : 1;
      cw = 8 + c;
      rw = 11 + r;
      if (b)
         ln = (s == 0) ? 4'h1 << a[1:0] : (s == 1) ? 4'h3 << {a[1], 1'b0} : 4'hF;
      else
         ln = (s == 0) ? 4'h1 << a[0] : 4'h3;
      return {2'((a >> (cb + cw + rw)) & 3), 13'((a >> (cb + cw)) & ((1 << rw) - 1)),
              11'((a >> cb) & ((1 << cw) - 1)), b ? a[1:0] : {1'b0, a[0]}, a[0], ln};
   endfunction

   task automatic chk(string n, logic [25:0] seen, logic [25:0] exv);
      check_count++;
      if (seen !== exv)
      begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", n, exv, seen);
      end
   endtask

   task automatic final_report();
      $display("Checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // One cycle: drive a request, then check what the previous one produced
   task automatic step(bit v, logic [27:0] a, int s);
      @(posedge clk_i);
      cfg_bus_i   <= sdam_bus_e'(gb[0]);
      cfg_rows_i  <= sdam_rows_e'(gr[1:0]);
      cfg_cols_i  <= sdam_cols_e'(gc[1:0]);
      req_valid_i <= v;
      req_addr_i  <= a;
      req_size_i  <= sdam_size_e'(s[1:0]);
      @(negedge clk_i);
      chk("valid", map_valid_o, ev);
      chk("row", row_o, ex[30:18]);
      chk("col", col_o, ex[17:7]);
      chk("bank", grp_o, ex[32:31]);
      chk("pins", {gh_o, gl_o}, ex[32:31]);
      chk("offs", offs_o, ex[6:5]);
      chk("half", hb_o, ex[4]);
      chk("lanes", lanes_o, ex[3:0]);
      if (ok2)
         chk("loc", loc, lag);
      lag = {ex[32:31], ex[30:18], ex[17:7]};
      ok2 = ok1;
      ok1 |= v;
      if (v)
         ex = exp_map(gb, gr, gc, s, a);
      ev = v;
   endtask

   // Hang guard: the sequence needs about 1100 cycles
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         final_report();
      end
   end

   // ==========================================================================
   // Main sequence: every geometry, corner addresses, then random traffic
   initial
   begin
      // Non-blocking so the reset flops already wait for the falling edge
      rstn_i <= 1'b0;
      req_valid_i = 1'b0;
      req_addr_i = 28'h0;
      req_size_i = SDAM_SIZE_BYTE;
      cfg_bus_i = SDAM_BUS_16;
      cfg_rows_i = SDAM_ROWS_2K;
      cfg_cols_i = SDAM_COLS_256;
      ex = '0;
      ev = 1'b0;
      void'($urandom(32'hD3D00A78));
      repeat (6) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (3) step(1'b0, 28'h0, 0);
      for (int g = 0; g < 24; g++)
      begin
         gb = g % 2;
         gr = (g / 2) % 3;
         gc = g / 6;
         step(1'b0, 28'h0, 0);
         step(1'b1, 28'hFFFFFFF, 2);
         step(1'b1, 28'h0, 0);
         step(1'b1, 28'hF800000, 1);
         repeat (40) step($urandom_range(3) != 0, 28'($urandom), $urandom_range(2));
      end
      step(1'b0, 28'h0, 0);
      final_report();
   end
endmodule
